// >>> inc/lcp_pkg.sv
// Constants, types and register map for the cache and DRAM pin controller.
//
// Operation
// - Cache off: shared lines carry DRAM address bits 11 to 4 only.
// - Cache on: shared lines carry address with tag enable high, tag data when low.
// - Tag output enable stays high during every DRAM access.
// - Tag write enable low on burst fill and on 7+1 write hit to a clean line.
// - Cache on: cache output enable asserted at the start of every memory read.
// - Read that misses drops cache output enable at the next clock edge.
// - Active-low byte write enable writes selected bytes into cache SRAM.
// - Active-low global write writes the full 32-bit word into the cache.
// - Active-low advance steps the burst SRAM address counter.
// - DRAM write strobe low performs a DRAM write.
// - EDO DRAM: write strobe pulses low to end a read cycle.
// - DRAM write strobe held high during every refresh.
// - Four active-low row strobes, strobe n serves bank n.
// - Four active-low column strobes, one per byte lane.
// - Low address pins are straps while power-good low, address after reset out falls.
// - Strap bit 0 high enables keyboard controller, strap bit 1 enables clock.
// - System reset output is high while power-good is low, registered one host clock behind it.
// - Power-good low puts the internal logic in a known state.
// - All cache and DRAM outputs are sequenced on the host clock.
package lcp_pkg;

  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CTRL_W = 4;
  localparam int CTRL_CACHE_EN = 0;
  localparam int CTRL_TAG71 = 1;
  localparam int CTRL_EDO = 2;
  localparam int CTRL_TAG_VALID = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int STAT_W = 8;
  localparam int STAT_HIT = 4;
  localparam int STAT_BUSY = 5;

  localparam int STRAP_KBC = 0;
  localparam int STRAP_RTC = 1;
  localparam logic [3:0] STRAP_RESET = 4'hF;

  localparam int TAG_LO = 19;
  localparam int DIRTY_BIT = 7;
  localparam int BANK_LO = 22;
  localparam int ROW_LO = 10;
  localparam int COL_LO = 2;

  localparam logic [2:0] ROW_WAIT = 3'h1;
  localparam logic [2:0] COL_WAIT = 3'h1;
  localparam logic [2:0] REF_WAIT = 3'h3;
  localparam logic [2:0] BURST_LAST = 3'h3;
  localparam logic [11:0] REF_ROW_RESET = 12'h000;

  typedef enum {ST_IDLE, ST_TAG, ST_HIT_RD, ST_HIT_WR, ST_ROW, ST_COL, ST_END, ST_FILL, ST_REF} lcp_state_t;

  typedef struct packed {
    logic toe_n;
    logic twe_n;
    logic coe_n;
    logic bwe_n;
    logic gw_n;
    logic adv_n;
    logic mwe_n;
    logic [3:0] ras_n;
    logic [3:0] cas_n;
    logic bus_oe_n;
    logic [7:0] bus;
    logic [3:0] low;
  } lcp_pins_t;

  localparam lcp_pins_t PINS_IDLE = '{toe_n: 1'b1, twe_n: 1'b1, coe_n: 1'b1, bwe_n: 1'b1, gw_n: 1'b1,
    adv_n: 1'b1, mwe_n: 1'b1, ras_n: 4'hF, cas_n: 4'hF, bus_oe_n: 1'b0, bus: 8'h00, low: 4'h0};

endpackage

// >>> inc/lcp_reg_if.sv
// Control and status bundle between the register slave and the pin sequencer.
`timescale 1ns/1ps
`default_nettype none
interface lcp_reg_if;
  import lcp_pkg::*;
  logic [CTRL_W-1:0] ctrl;
  logic [STAT_W-1:0] status;
  modport regs (output ctrl, input status);
  modport core (input ctrl, output status);
endinterface
`default_nettype wire

// >>> tb/l2_cache_dram_pin_control_tb.sv
// Self-checking bench for the cache and DRAM pin controller.
`timescale 1ns/1ps
`default_nettype none
module l2_cache_dram_pin_control_tb
  import lcp_pkg::*;
();
  logic I_SYS_CLK = 1'b0, I_RST_B = 1'b0, I_PWR_GOOD = 1'b0, I_AWVALID = 1'b0, I_WVALID = 1'b0;
  logic I_BREADY = 1'b0, I_ARVALID = 1'b0, I_RREADY = 1'b0, I_MEM_REQ = 1'b0, I_MEM_WE = 1'b0, I_REF_REQ = 1'b0;
  logic [AXI_AW-1:0] I_AWADDR = '0, I_ARADDR = '0;
  logic [31:0] I_WDATA = '0, I_MEM_ADDR = '0, O_RDATA, rd;
  logic [3:0] I_WSTRB = 4'hF, I_MEM_BE = 4'hF, strap = 4'hD, ras_lo, cas_lo;
  logic [7:0] tag = 8'h09, O_SHARED_ADDR_TAG;
  wire logic [7:0] I_SHARED_ADDR_TAG;
  wire logic [3:0] I_LOW_ADDR_STRAP;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_MEM_BUSY, O_MEM_DONE, O_MEM_HIT;
  logic O_SHARED_ADDR_TAG_OE_N, O_LOW_ADDR_STRAP_OE_N, O_TAG_OUTPUT_ENABLE_N, O_TAG_WRITE_ENABLE_N;
  logic O_CACHE_OUTPUT_ENABLE_N, O_CACHE_BYTE_WRITE_N, O_CACHE_GLOBAL_WRITE_N, O_BURST_ADVANCE_N;
  logic O_DRAM_WRITE_STROBE_N, O_SYSTEM_RESET_OUT, O_KBC_EN, O_RTC_EN, c1_coe, c2_coe;
  logic [1:0] O_BRESP, O_RRESP, rr;
  logic [3:0] O_LOW_ADDR_STRAP, O_ROW_STROBE_N, O_COL_STROBE_N;
  logic [6:0] lo;
  logic [13:0] c1_pins;
  logic [11:0] c3_addr;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  lcp_pin_ctrl u_lcp_pin_ctrl (.*);
  lcp_mem_model u_lcp_mem_model (.i_clk(I_SYS_CLK), .i_tag(tag), .i_toe_n(O_TAG_OUTPUT_ENABLE_N),
    .i_bus_oe_n(O_SHARED_ADDR_TAG_OE_N), .i_bus(O_SHARED_ADDR_TAG), .o_bus(I_SHARED_ADDR_TAG),
    .i_strap(strap), .i_low_oe_n(O_LOW_ADDR_STRAP_OE_N), .i_low(O_LOW_ADDR_STRAP), .o_low(I_LOW_ADDR_STRAP));
  always #50 I_SYS_CLK = ~I_SYS_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_SYS_CLK);
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_BREADY <= 1'b1;
    do begin
      @(posedge I_SYS_CLK);
      if (O_AWREADY) I_AWVALID <= 1'b0;
      if (O_WREADY) I_WVALID <= 1'b0;
    end while (O_BVALID !== 1'b1);
    I_BREADY <= 1'b0;
    rr = O_BRESP;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge I_SYS_CLK);
    I_ARVALID <= 1'b1;
    I_ARADDR <= a;
    I_RREADY <= 1'b1;
    do begin
      @(posedge I_SYS_CLK);
      if (O_ARREADY) I_ARVALID <= 1'b0;
    end while (O_RVALID !== 1'b1);
    I_RREADY <= 1'b0;
    rd = O_RDATA;
    rr = O_RRESP;
  endtask
  // Strobes are gathered as ever-low masks over the whole cycle, in the order TOE TWE COE BWE GW ADV MWE.
  task automatic mem(input logic we, input logic r, input logic [31:0] a, input logic [3:0] be);
    int k;
    @(posedge I_SYS_CLK);
    I_MEM_REQ <= !r;
    I_REF_REQ <= r;
    I_MEM_WE <= we;
    I_MEM_ADDR <= a;
    I_MEM_BE <= be;
    @(posedge I_SYS_CLK);
    I_MEM_REQ <= 1'b0;
    I_REF_REQ <= 1'b0;
    lo = '0;
    ras_lo = '0;
    cas_lo = '0;
    k = 0;
    do begin
      @(negedge I_SYS_CLK);
      k++;
      lo |= ~{O_TAG_OUTPUT_ENABLE_N, O_TAG_WRITE_ENABLE_N, O_CACHE_OUTPUT_ENABLE_N, O_CACHE_BYTE_WRITE_N,
        O_CACHE_GLOBAL_WRITE_N, O_BURST_ADVANCE_N, O_DRAM_WRITE_STROBE_N};
      ras_lo |= ~O_ROW_STROBE_N;
      cas_lo |= ~O_COL_STROBE_N;
      if (k == 1) c1_coe = O_CACHE_OUTPUT_ENABLE_N;
      if (k == 2) c2_coe = O_CACHE_OUTPUT_ENABLE_N;
      if (k == 1) c1_pins = {O_MEM_BUSY, O_SHARED_ADDR_TAG_OE_N, O_SHARED_ADDR_TAG, O_LOW_ADDR_STRAP};
      if (k == 3) c3_addr = {O_SHARED_ADDR_TAG, O_LOW_ADDR_STRAP};
    end while (O_MEM_DONE !== 1'b1 && k < 40);
    chk("done", 32'h1, O_MEM_DONE);
  endtask
  always @(posedge I_SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      chk("timeout", 32'h0, 32'h1);
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge I_SYS_CLK);
    I_RST_B <= 1'b1;
    repeat (3) @(posedge I_SYS_CLK);
    chk("rst_out", 32'h1, O_SYSTEM_RESET_OUT);
    chk("low_oe_n", 32'h1, O_LOW_ADDR_STRAP_OE_N);
    I_PWR_GOOD <= 1'b1;
    repeat (3) @(posedge I_SYS_CLK);
    chk("rst_out", 32'h0, O_SYSTEM_RESET_OUT);
    chk("low_oe_n", 32'h0, O_LOW_ADDR_STRAP_OE_N);
    chk("kbc", 32'h1, O_KBC_EN);
    chk("rtc", 32'h0, O_RTC_EN);
    rdr(REG_STAT);
    chk("stat", 32'h4D, rd);
    rdr(8'h40);
    chk("rresp", RESP_SLVERR, rr);
    wr(8'h40, 32'h0);
    chk("bresp", RESP_SLVERR, rr);
    rdr(REG_CTRL);
    chk("ctrl", CTRL_RESET, rd);
    mem(1'b0, 1'b0, 32'h00C1_2340, 4'h5);
    chk("rd_pins", 32'h00, lo);
    chk("row_pins", 32'h2048, c1_pins);
    chk("col_addr", 32'h0D0, c3_addr);
    chk("ras", 32'h8, ras_lo);
    chk("cas", 32'h5, cas_lo);
    mem(1'b1, 1'b0, 32'h0000_0000, 4'hA);
    chk("wr_pins", 32'h01, lo);
    chk("ras", 32'h1, ras_lo);
    chk("cas", 32'hA, cas_lo);
    wr(REG_CTRL, 32'h4);
    mem(1'b0, 1'b0, 32'h0000_0000, 4'hF);
    chk("edo_pins", 32'h01, lo);
    mem(1'b0, 1'b1, 32'h0000_0000, 4'hF);
    chk("ref_pins", 32'h00, lo);
    chk("ref_ras", 32'hF, ras_lo);
    wr(REG_CTRL, 32'h9);
    rdr(REG_CTRL);
    chk("ctrl", 32'h9, rd[3:0]);
    mem(1'b0, 1'b0, 32'h0048_0000, 4'hF);
    chk("c1_coe", 32'h0, c1_coe);
    chk("hit_pins", 32'h52, lo);
    chk("tag_oe", 32'h3, c1_pins[13:12]);
    chk("hit", 32'h1, O_MEM_HIT);
    mem(1'b1, 1'b0, 32'h0048_0000, 4'hF);
    chk("gw", 32'h1, lo[3:2]);
    mem(1'b1, 1'b0, 32'h0048_0000, 4'h3);
    chk("bwe", 32'h2, lo[3:2]);
    tag <= 8'h0A;
    mem(1'b0, 1'b0, 32'h0048_0000, 4'hF);
    chk("c1_coe", 32'h0, c1_coe);
    chk("c2_coe", 32'h1, c2_coe);
    chk("miss_pins", 32'h76, lo);
    chk("hit", 32'h0, O_MEM_HIT);
    chk("ras", 32'h2, ras_lo);
    wr(REG_CTRL, 32'hB);
    tag <= 8'h09;
    mem(1'b1, 1'b0, 32'h0048_0000, 4'hF);
    chk("wr71_pins", 32'h64, lo);
    @(posedge I_SYS_CLK);
    I_PWR_GOOD <= 1'b0;
    repeat (3) @(posedge I_SYS_CLK);
    chk("rst_out", 32'h1, O_SYSTEM_RESET_OUT);
    chk("low_oe_n", 32'h1, O_LOW_ADDR_STRAP_OE_N);
    chk("hit", 32'h0, O_MEM_HIT);
    report_and_stop;
  end
endmodule // l2_cache_dram_pin_control_tb
`default_nettype wire

// >>> tb/lcp_mem_model.sv
// Behavioural tag RAM and strap jumpers on the shared memory pins.
`timescale 1ns/1ps
`default_nettype none
module lcp_mem_model (
  input wire logic i_clk,
  input wire logic [7:0] i_tag,
  input wire logic i_toe_n,
  input wire logic i_bus_oe_n,
  input wire logic [7:0] i_bus,
  output logic [7:0] o_bus,
  input wire logic [3:0] i_strap,
  input wire logic i_low_oe_n,
  input wire logic [3:0] i_low,
  output logic [3:0] o_low
);
  logic [7:0] last_q;
  always_ff @(posedge i_clk) begin
    last_q <= o_bus;
  end
  // A floating bus shows the inverse of its last level so stale data never matches.
  always_comb begin
    if (!i_bus_oe_n) o_bus = i_bus;
    else if (!i_toe_n) o_bus = i_tag;
    else o_bus = ~last_q;
  end
  // Jumpers pull the undriven low pins; the two upper bits must sit high.
  assign o_low = i_low_oe_n ? {2'b11, i_strap[1:0]} : i_low;
endmodule // lcp_mem_model
`default_nettype wire

// >>> verilog/lcp_axil_regs.sv
// AXI4-Lite register slave holding the control word and reading back status.
`timescale 1ns/1ps
`default_nettype none
module lcp_axil_regs
  import lcp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [AXI_AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [AXI_AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  lcp_reg_if.regs rif
);

  function automatic logic reg_mapped(input logic [AXI_AW-1:0] a);
    reg_mapped = (a[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) || (a[AXI_AW-1:2] == REG_STAT[AXI_AW-1:2]);
  endfunction

  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic commit;

  assign commit = aw_have_q && w_have_q && !o_bvalid;
  assign rif.ctrl = ctrl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data are taken in either order.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (commit) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Status is read-only; a write to it is answered but has no effect.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (commit && wstrb_q[0] && awaddr_q[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
      ctrl_q <= wdata_q[CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= reg_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (i_araddr[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
        o_rdata <= {{(32-CTRL_W){1'b0}}, ctrl_q};
      end else if (i_araddr[AXI_AW-1:2] == REG_STAT[AXI_AW-1:2]) begin
        o_rdata <= {{(32-STAT_W){1'b0}}, rif.status};
      end else begin
        o_rdata <= '0;
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule // lcp_axil_regs
`default_nettype wire

// >>> verilog/lcp_pin_ctrl.sv
// Cache SRAM, tag RAM and DRAM pin sequencer with strap capture and reset output.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcp_pin_ctrl
  import lcp_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic I_PWR_GOOD,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [AXI_AW-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [AXI_AW-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_MEM_REQ,
  input wire logic I_MEM_WE,
  input wire logic [31:0] I_MEM_ADDR,
  input wire logic [3:0] I_MEM_BE,
  input wire logic I_REF_REQ,
  output logic O_MEM_BUSY,
  output logic O_MEM_DONE,
  output logic O_MEM_HIT,
  input wire logic [7:0] I_SHARED_ADDR_TAG,
  output logic [7:0] O_SHARED_ADDR_TAG,
  output logic O_SHARED_ADDR_TAG_OE_N,
  input wire logic [3:0] I_LOW_ADDR_STRAP,
  output logic [3:0] O_LOW_ADDR_STRAP,
  output logic O_LOW_ADDR_STRAP_OE_N,
  output logic O_TAG_OUTPUT_ENABLE_N,
  output logic O_TAG_WRITE_ENABLE_N,
  output logic O_CACHE_OUTPUT_ENABLE_N,
  output logic O_CACHE_BYTE_WRITE_N,
  output logic O_CACHE_GLOBAL_WRITE_N,
  output logic O_BURST_ADVANCE_N,
  output logic O_DRAM_WRITE_STROBE_N,
  output logic [3:0] O_ROW_STROBE_N,
  output logic [3:0] O_COL_STROBE_N,
  output logic O_SYSTEM_RESET_OUT,
  output logic O_KBC_EN,
  output logic O_RTC_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // Address slicing shared by the start of a cycle, a miss and a fill.
  function automatic logic [3:0] bank_sel_n(input logic [31:0] a);
    bank_sel_n = ~(4'h1 << a[BANK_LO +: 2]);
  endfunction

  function automatic logic [11:0] row_addr(input logic [31:0] a);
    row_addr = a[ROW_LO +: 12];
  endfunction

  function automatic logic [11:0] col_addr(input logic [31:0] a);
    col_addr = {4'h0, a[COL_LO +: 8]};
  endfunction

  // In 7+1 mode the top tag bit is the dirty flag, not an address bit.
  function automatic logic [7:0] tag_value(input logic [31:0] a, input logic m71, input logic dirty);
    tag_value = m71 ? {dirty, a[TAG_LO +: 7]} : a[TAG_LO +: 8];
  endfunction

  function automatic logic tag_match(input logic [7:0] tag, input logic [31:0] a, input logic m71, input logic vld);
    logic [7:0] want;
    want = a[TAG_LO +: 8];
    if (m71) begin
      tag_match = vld && (tag[6:0] == want[6:0]);
    end else begin
      tag_match = vld && (tag == want);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  lcp_reg_if rif ();

  lcp_axil_regs u_regs (
    .i_clk(I_SYS_CLK),
    .i_rst_b(I_RST_B),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_awaddr(I_AWADDR),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .o_bresp(O_BRESP),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .i_araddr(I_ARADDR),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .rif(rif)
  );

  logic cache_en;
  logic tag71;
  logic edo;
  logic tag_valid;
  logic hit_w;
  logic take;
  lcp_state_t state_q;
  lcp_pins_t pins_q;
  logic [2:0] cnt_q;
  logic [31:0] addr_q;
  logic we_q;
  logic [3:0] be_q;
  logic [11:0] ref_row_q;
  logic busy_q;
  logic done_q;
  logic hit_q;
  logic sys_rst_q;
  logic low_oe_n_q;
  logic [3:0] strap_q;

  assign cache_en = rif.ctrl[CTRL_CACHE_EN];
  assign tag71 = rif.ctrl[CTRL_TAG71];
  assign edo = rif.ctrl[CTRL_EDO];
  assign tag_valid = rif.ctrl[CTRL_TAG_VALID];
  assign hit_w = tag_match(I_SHARED_ADDR_TAG, addr_q, tag71, tag_valid);
  assign take = I_PWR_GOOD && state_q == ST_IDLE && I_MEM_REQ && !I_REF_REQ;
  assign rif.status = {strap_q[STRAP_RTC], strap_q[STRAP_KBC], busy_q, hit_q, strap_q};

  ////////////////////////////////////////////////////////////////////////////
  // Power-good supervision and strap capture. The straps are sampled on every
  // clock while power-good is low, so the last value before release is kept.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sys_rst_q <= 1'b1;
      low_oe_n_q <= 1'b1;
      strap_q <= STRAP_RESET;
    end else begin
      sys_rst_q <= !I_PWR_GOOD;
      low_oe_n_q <= sys_rst_q || !I_PWR_GOOD;
      if (!I_PWR_GOOD) begin
        strap_q <= I_LOW_ADDR_STRAP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory cycle sequencer. Every pin changes only at a host clock edge.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q <= ST_IDLE;
      pins_q <= PINS_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      we_q <= 1'b0;
      be_q <= '0;
      ref_row_q <= REF_ROW_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (!I_PWR_GOOD) begin
      state_q <= ST_IDLE;
      pins_q <= PINS_IDLE;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (I_REF_REQ) begin
            // RAS-only refresh of all banks at once.
            state_q <= ST_REF;
            cnt_q <= REF_WAIT;
            busy_q <= 1'b1;
            pins_q.toe_n <= 1'b1;
            pins_q.mwe_n <= 1'b1;
            pins_q.bus_oe_n <= 1'b0;
            {pins_q.bus, pins_q.low} <= ref_row_q;
            pins_q.ras_n <= 4'h0;
          end else if (I_MEM_REQ) begin
            addr_q <= I_MEM_ADDR;
            we_q <= I_MEM_WE;
            be_q <= I_MEM_BE;
            busy_q <= 1'b1;
            if (cache_en) begin
              state_q <= ST_TAG;
              pins_q.bus_oe_n <= 1'b1;
              pins_q.toe_n <= 1'b0;
              pins_q.coe_n <= I_MEM_WE;
            end else begin
              state_q <= ST_ROW;
              cnt_q <= ROW_WAIT;
              pins_q.toe_n <= 1'b1;
              pins_q.bus_oe_n <= 1'b0;
              {pins_q.bus, pins_q.low} <= row_addr(I_MEM_ADDR);
              pins_q.ras_n <= bank_sel_n(I_MEM_ADDR);
            end
          end
        end
        ST_TAG: begin
          // The tag RAM has driven the shared lines for one full cycle.
          pins_q.toe_n <= 1'b1;
          hit_q <= hit_w;
          if (hit_w && !we_q) begin
            state_q <= ST_HIT_RD;
            cnt_q <= BURST_LAST;
            pins_q.adv_n <= 1'b0;
          end else if (hit_w) begin
            state_q <= ST_HIT_WR;
            if (&be_q) begin
              pins_q.gw_n <= 1'b0;
            end else begin
              pins_q.bwe_n <= 1'b0;
            end
            if (tag71 && !I_SHARED_ADDR_TAG[DIRTY_BIT]) begin
              pins_q.twe_n <= 1'b0;
              pins_q.bus <= tag_value(addr_q, 1'b1, 1'b1);
              pins_q.bus_oe_n <= 1'b0;
            end
          end else begin
            state_q <= ST_ROW;
            cnt_q <= ROW_WAIT;
            pins_q.coe_n <= 1'b1;
            pins_q.bus_oe_n <= 1'b0;
            {pins_q.bus, pins_q.low} <= row_addr(addr_q);
            pins_q.ras_n <= bank_sel_n(addr_q);
          end
        end
        ST_HIT_RD: begin
          if (cnt_q == 3'h0) begin
            state_q <= ST_IDLE;
            pins_q <= PINS_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        ST_HIT_WR: begin
          state_q <= ST_IDLE;
          pins_q <= PINS_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        ST_ROW: begin
          if (cnt_q == 3'h0) begin
            state_q <= ST_COL;
            cnt_q <= COL_WAIT;
            {pins_q.bus, pins_q.low} <= col_addr(addr_q);
            pins_q.cas_n <= ~be_q;
            pins_q.mwe_n <= !we_q;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        ST_COL: begin
          if (cnt_q == 3'h0) begin
            state_q <= ST_END;
            pins_q.ras_n <= 4'hF;
            pins_q.cas_n <= 4'hF;
            pins_q.mwe_n <= !(edo && !we_q);
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        ST_END: begin
          pins_q.mwe_n <= 1'b1;
          // A read that reaches DRAM with the cache on was a miss: refill the line.
          if (cache_en && !we_q) begin
            state_q <= ST_FILL;
            cnt_q <= BURST_LAST;
            pins_q.gw_n <= 1'b0;
            pins_q.twe_n <= 1'b0;
            pins_q.bus <= tag_value(addr_q, tag71, 1'b0);
            pins_q.bus_oe_n <= 1'b0;
          end else begin
            state_q <= ST_IDLE;
            pins_q <= PINS_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        ST_FILL: begin
          pins_q.twe_n <= 1'b1;
          pins_q.adv_n <= 1'b0;
          if (cnt_q == 3'h0) begin
            state_q <= ST_IDLE;
            pins_q <= PINS_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        ST_REF: begin
          if (cnt_q == 3'h0) begin
            state_q <= ST_IDLE;
            pins_q <= PINS_IDLE;
            ref_row_q <= ref_row_q + 12'h001;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign O_MEM_BUSY = busy_q;
  assign O_MEM_DONE = done_q;
  assign O_MEM_HIT = hit_q;
  assign O_SHARED_ADDR_TAG = pins_q.bus;
  assign O_SHARED_ADDR_TAG_OE_N = pins_q.bus_oe_n;
  assign O_LOW_ADDR_STRAP = pins_q.low;
  assign O_LOW_ADDR_STRAP_OE_N = low_oe_n_q;
  assign O_TAG_OUTPUT_ENABLE_N = pins_q.toe_n;
  assign O_TAG_WRITE_ENABLE_N = pins_q.twe_n;
  assign O_CACHE_OUTPUT_ENABLE_N = pins_q.coe_n;
  assign O_CACHE_BYTE_WRITE_N = pins_q.bwe_n;
  assign O_CACHE_GLOBAL_WRITE_N = pins_q.gw_n;
  assign O_BURST_ADVANCE_N = pins_q.adv_n;
  assign O_DRAM_WRITE_STROBE_N = pins_q.mwe_n;
  assign O_ROW_STROBE_N = pins_q.ras_n;
  assign O_COL_STROBE_N = pins_q.cas_n;
  assign O_SYSTEM_RESET_OUT = sys_rst_q;
  assign O_KBC_EN = strap_q[STRAP_KBC];
  assign O_RTC_EN = strap_q[STRAP_RTC];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);

  property p_nocache_addr;
    (busy_q && !cache_en) |-> (pins_q.toe_n && !pins_q.bus_oe_n);
  endproperty
  a_nocache_addr: assert property (p_nocache_addr) else $error("Shared lines not address-only with cache off.");

  property p_bus_turn;
    !pins_q.toe_n |-> pins_q.bus_oe_n;
  endproperty
  a_bus_turn: assert property (p_bus_turn) else $error("Shared lines driven while tag RAM enabled.");

  property p_toe_dram;
    (pins_q.ras_n != 4'hF || pins_q.cas_n != 4'hF) |-> pins_q.toe_n;
  endproperty
  a_toe_dram: assert property (p_toe_dram) else $error("Tag output enabled during DRAM access.");

  property p_coe_start;
    (take && cache_en && !I_MEM_WE) |=> (!pins_q.coe_n && state_q == ST_TAG);
  endproperty
  a_coe_start: assert property (p_coe_start) else $error("Cache output enable missing at read start.");

  property p_coe_miss;
    (I_PWR_GOOD && state_q == ST_TAG && !hit_w) |=> (pins_q.coe_n && state_q == ST_ROW);
  endproperty
  a_coe_miss: assert property (p_coe_miss) else $error("Cache output enable held after a miss.");

  property p_hit_burst;
    disable iff (!I_RST_B || !I_PWR_GOOD)
    (state_q == ST_TAG && hit_w && !we_q) |=> (!pins_q.adv_n [*4] ##1 (pins_q.adv_n && done_q));
  endproperty
  a_hit_burst: assert property (p_hit_burst) else $error("Hit burst advance not four cycles.");

  property p_dram_write;
    (I_PWR_GOOD && state_q == ST_ROW && cnt_q == 3'h0) |=> (pins_q.mwe_n == !we_q && pins_q.cas_n == ~be_q);
  endproperty
  a_dram_write: assert property (p_dram_write) else $error("Column strobe or write strobe wrong.");

  property p_edo_end;
    (I_PWR_GOOD && state_q == ST_COL && cnt_q == 3'h0 && edo && !we_q) |=> !pins_q.mwe_n ##1 pins_q.mwe_n;
  endproperty
  a_edo_end: assert property (p_edo_end) else $error("EDO read not ended by a one-cycle write pulse.");

  property p_ref_mwe;
    (state_q == ST_REF) |-> (pins_q.mwe_n && pins_q.ras_n == 4'h0);
  endproperty
  a_ref_mwe: assert property (p_ref_mwe) else $error("Write strobe low during refresh.");

  property p_row_bank;
    (state_q == ST_ROW) |-> (pins_q.ras_n == bank_sel_n(addr_q));
  endproperty
  a_row_bank: assert property (p_row_bank) else $error("Row strobe does not match bank.");

  property p_strap_release;
    (sys_rst_q && $past(I_RST_B)) |-> (low_oe_n_q && strap_q == $past(I_LOW_ADDR_STRAP));
  endproperty
  a_strap_release: assert property (p_strap_release) else $error("Straps driven or not captured in reset.");

  property p_sys_rst;
    sys_rst_q == !$past(I_PWR_GOOD);
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("Reset output does not follow power-good.");

endmodule // lcp_pin_ctrl
`default_nettype wire
